// ### logic/pgsm_pkg.sv
package pgsm_pkg;

  // ****************************************
  // register map (printed offsets are indices)
  // ****************************************
  localparam logic [7:0] PGSM_IDX_PAD_OUTPUT_ENABLE = 8'h44;
  localparam logic [7:0] PGSM_IDX_PAD_OUTPUT_VALUE = 8'h45;
  localparam logic [7:0] PGSM_IDX_PAD_INPUT_LEVEL = 8'h46;
  localparam logic [7:0] PGSM_IDX_MONITOR_OUTPUT_SELECT = 8'h47;
  localparam logic [7:0] PGSM_IDX_SILICON_REVISION = 8'h7f;

  // ****************************************
  // reset values and fields
  // ****************************************
  localparam logic [7:0] PGSM_RST_PAD_OUTPUT_ENABLE = 8'h00;
  localparam logic [7:0] PGSM_RST_PAD_OUTPUT_VALUE = 8'h00;
  localparam logic [3:0] PGSM_RST_MONITOR_SOURCE = 4'h0;
  localparam logic PGSM_RST_FAST_PAD = 1'b0;
  localparam int PGSM_BIT_SIGNAL_INPUT = 7;
  localparam int PGSM_BIT_CLOCK_OUTPUT = 6;
  localparam int PGSM_BIT_FAST_PAD = 7;
  localparam logic [7:0] PGSM_SCAN_PIN_MASK = 8'h0f;
  localparam logic [7:0] PGSM_MONITOR_SELECT_MASK = 8'h8f;

  // ****************************************
  // monitor source codes
  // ****************************************
  typedef enum logic [3:0] {
    PGSM_MON_OFF0 = 4'b0000,
    PGSM_MON_OFF1 = 4'b0001,
    PGSM_MON_LOW = 4'b0010,
    PGSM_MON_HIGH = 4'b0011,
    PGSM_MON_TX_ENVELOPE = 4'b0100,
    PGSM_MON_TX_ACTIVE = 4'b0101,
    PGSM_MON_SECURE_CHANNEL = 4'b0110,
    PGSM_MON_RX_ENVELOPE = 4'b0111,
    PGSM_MON_RX_ACTIVE = 4'b1000,
    PGSM_MON_RX_BIT = 4'b1001
  } pgsm_monitor_e;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic tx_envelope;
    logic tx_active;
    logic generic_secure_channel_signal;
    logic rx_envelope;
    logic rx_active;
    logic rx_bit;
  } pgsm_debug_s;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pgsm_pads_s;

endpackage : pgsm_pkg

// ### logic/pgsm_gpio.sv
`timescale 1ns/1ns
module pgsm_gpio #(
  parameter logic [3:0] SILICON_VERSION = 4'h3, // arbitrary
  parameter logic [3:0] SILICON_SUBVERSION = 4'h5 // arbitrary
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pads
  input wire logic [7:0] pin_level,
  output pgsm_pkg::pgsm_pads_s pads,
  input wire logic scan_active,
  input wire logic clock_output_func,
  output logic fast_pad_switching,
  // monitor
  input wire pgsm_pkg::pgsm_debug_s debug,
  output logic monitor_output_pin_out,
  output logic monitor_output_pin_oe
);
  import pgsm_pkg::*;

  // ****************************************
  // bus decode
  // ****************************************
  logic [7:0] pad_output_enable;
  logic [7:0] pad_output_value;
  logic [3:0] monitor_source_code;
  logic fast_pad;
  logic wr_pend;
  logic [7:0] wr_idx;
  logic addr_phase;
  logic [7:0] idx;
  logic [7:0] next_rdata;
  logic wr_hit;
  logic [7:0] sel_word;

  function automatic logic [7:0] reg_index(input logic [31:0] a);
    reg_index = a[9:2];
  endfunction : reg_index

  // a write finishing at this edge is handed to a read sampled at the same edge
  function automatic logic [7:0] fwd(input logic hit, input logic [7:0] wd, input logic [7:0] q);
    fwd = hit ? wd : q;
  endfunction : fwd

  assign addr_phase = hsel && hready && htrans[1];
  assign idx = reg_index(haddr);
  assign wr_hit = wr_pend && (wr_idx == idx);
  assign sel_word = {fast_pad, 3'h0, monitor_source_code};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
    end
    else
    begin
      wr_pend <= addr_phase && hwrite;
      wr_idx <= idx;
    end
  end

  always_comb
  begin
    case (idx)
      PGSM_IDX_PAD_OUTPUT_ENABLE: next_rdata = fwd(wr_hit, hwdata[7:0], pad_output_enable);
      PGSM_IDX_PAD_OUTPUT_VALUE: next_rdata = fwd(wr_hit, hwdata[7:0], pad_output_value);
      PGSM_IDX_PAD_INPUT_LEVEL: next_rdata = pin_level;
      PGSM_IDX_MONITOR_OUTPUT_SELECT:
        next_rdata = fwd(wr_hit, hwdata[7:0] & PGSM_MONITOR_SELECT_MASK, sel_word);
      PGSM_IDX_SILICON_REVISION: next_rdata = {SILICON_VERSION, SILICON_SUBVERSION};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (addr_phase && !hwrite)
      hrdata <= {24'h00_0000, next_rdata};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pad_output_enable <= PGSM_RST_PAD_OUTPUT_ENABLE;
      pad_output_value <= PGSM_RST_PAD_OUTPUT_VALUE;
      monitor_source_code <= PGSM_RST_MONITOR_SOURCE;
      fast_pad <= PGSM_RST_FAST_PAD;
    end
    else if (wr_pend)
    begin
      case (wr_idx)
        PGSM_IDX_PAD_OUTPUT_ENABLE: pad_output_enable <= hwdata[7:0];
        PGSM_IDX_PAD_OUTPUT_VALUE: pad_output_value <= hwdata[7:0];
        PGSM_IDX_MONITOR_OUTPUT_SELECT:
        begin
          fast_pad <= hwdata[PGSM_BIT_FAST_PAD];
          monitor_source_code <= hwdata[3:0];
        end
        default:
        begin
        end
      endcase
    end
  end

  // ****************************************
  // pad drivers
  // ****************************************
  logic [7:0] next_oe;
  logic [7:0] next_out;

  always_comb
  begin
    next_oe = pad_output_enable;
    if (scan_active)
      next_oe = pad_output_enable & ~PGSM_SCAN_PIN_MASK;
    next_out = pad_output_value;
    if (!pad_output_enable[PGSM_BIT_CLOCK_OUTPUT])
    begin
      next_out[PGSM_BIT_CLOCK_OUTPUT] = clock_output_func;
      next_oe[PGSM_BIT_CLOCK_OUTPUT] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pads <= '0;
      fast_pad_switching <= PGSM_RST_FAST_PAD;
    end
    else
    begin
      pads.oe <= next_oe;
      pads.out <= next_out;
      fast_pad_switching <= fast_pad;
    end
  end

  // ****************************************
  // monitor output
  // ****************************************
  logic next_mon;
  logic next_mon_oe;

  always_comb
  begin
    next_mon = 1'b0;
    next_mon_oe = 1'b1;
    case (pgsm_monitor_e'(monitor_source_code))
      PGSM_MON_OFF0, PGSM_MON_OFF1: next_mon_oe = 1'b0;
      PGSM_MON_LOW: next_mon = 1'b0;
      PGSM_MON_HIGH: next_mon = 1'b1;
      PGSM_MON_TX_ENVELOPE: next_mon = debug.tx_envelope;
      PGSM_MON_TX_ACTIVE: next_mon = debug.tx_active;
      PGSM_MON_SECURE_CHANNEL: next_mon = debug.generic_secure_channel_signal;
      PGSM_MON_RX_ENVELOPE: next_mon = debug.rx_envelope;
      PGSM_MON_RX_ACTIVE: next_mon = debug.rx_active;
      PGSM_MON_RX_BIT: next_mon = debug.rx_bit;
      default: next_mon_oe = 1'b0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      monitor_output_pin_out <= 1'b0;
      monitor_output_pin_oe <= 1'b0;
    end
    else
    begin
      monitor_output_pin_out <= next_mon;
      monitor_output_pin_oe <= next_mon_oe;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_scan_oe_masked: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(scan_active) |-> (pads.oe[3:0] == 4'h0))
    else $error("scan pin driven while scan active");
  a_oe_follows_reg: assert property (@(posedge hclk) disable iff (!hresetn)
    !$past(scan_active) |-> pads.oe[3:0] == $past(pad_output_enable[3:0]))
    else $error("pad enable mismatch");
  a_clk_pin_gpio: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(pad_output_enable[6]) |-> pads.out[6] == $past(pad_output_value[6]))
    else $error("clock pin not gpio");
  a_out_value: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend && wr_idx == PGSM_IDX_PAD_OUTPUT_VALUE |-> ##2 pads.out[5:0] == $past(hwdata[5:0], 2))
    else $error("output value not applied");
  a_rd_input: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_phase && !hwrite && idx == PGSM_IDX_PAD_INPUT_LEVEL |=> hrdata[7:0] == $past(pin_level))
    else $error("input level read wrong");
  a_fast_pad: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend && wr_idx == PGSM_IDX_MONITOR_OUTPUT_SELECT |->
    ##2 fast_pad_switching == $past(hwdata[7], 2))
    else $error("pad speed not applied");
  a_mon_tristate: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(monitor_source_code) < 4'h2 |-> !monitor_output_pin_oe)
    else $error("monitor driven when off");
  a_mon_high: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(monitor_source_code) == 4'h3 |-> monitor_output_pin_oe && monitor_output_pin_out)
    else $error("monitor not high");
  a_mon_tx_env: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(monitor_source_code) == 4'h4 |-> monitor_output_pin_out == $past(debug.tx_envelope))
    else $error("tx envelope not shown");
  a_mon_rx_env: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(monitor_source_code) == 4'h7 |-> monitor_output_pin_out == $past(debug.rx_envelope))
    else $error("rx envelope not shown");
  a_mon_rx_bit: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(monitor_source_code) == 4'h9 |-> monitor_output_pin_out == $past(debug.rx_bit))
    else $error("rx bit not shown");
  a_revision_read: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_phase && !hwrite && idx == PGSM_IDX_SILICON_REVISION |=>
    hrdata[7:0] == {SILICON_VERSION, SILICON_SUBVERSION})
    else $error("revision read wrong");
  a_mon_undoc: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(monitor_source_code) > 4'h9 |-> !monitor_output_pin_oe)
    else $error("undocumented code drives monitor");
  a_oe_upper_pins: assert property (@(posedge hclk) disable iff (!hresetn)
    pads.oe[7] == $past(pad_output_enable[7])
    && pads.oe[5:4] == $past(pad_output_enable[5:4]))
    else $error("upper pad enable mismatch");
  // first edge after reset still shows the reset enable on the clock pin
  a_clk_pin_func: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(hresetn) && !$past(pad_output_enable[6]) |->
    pads.oe[6] && pads.out[6] == $past(clock_output_func))
    else $error("clock function not on pin");
  a_out_top_bit: assert property (@(posedge hclk) disable iff (!hresetn)
    pads.out[7] == $past(pad_output_value[7]))
    else $error("top output value mismatch");
  a_read_fwd: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_phase && !hwrite && wr_hit && idx == PGSM_IDX_PAD_OUTPUT_VALUE |=>
    hrdata[7:0] == $past(hwdata[7:0]))
    else $error("write not seen by following read");
  a_mon_low: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(monitor_source_code) == 4'h2 |-> monitor_output_pin_oe && !monitor_output_pin_out)
    else $error("monitor not low");
  a_mon_tx_active: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(monitor_source_code) == 4'h5 |-> monitor_output_pin_out == $past(debug.tx_active))
    else $error("tx active not shown");
  a_mon_secure: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(monitor_source_code) == 4'h6 |->
    monitor_output_pin_out == $past(debug.generic_secure_channel_signal))
    else $error("secure channel signal not shown");
  a_mon_rx_active: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(monitor_source_code) == 4'h8 |-> monitor_output_pin_out == $past(debug.rx_active))
    else $error("rx active not shown");

  c_write_enable: cover property (@(posedge hclk) disable iff (!hresetn)
    wr_pend && wr_idx == PGSM_IDX_PAD_OUTPUT_ENABLE);
  c_scan_block: cover property (@(posedge hclk) disable iff (!hresetn)
    scan_active && pad_output_enable[0]);
  c_mon_rx_bit: cover property (@(posedge hclk) disable iff (!hresetn)
    monitor_source_code == 4'h9);
  c_read_input: cover property (@(posedge hclk) disable iff (!hresetn)
    addr_phase && !hwrite && idx == PGSM_IDX_PAD_INPUT_LEVEL);
  c_write_read_fwd: cover property (@(posedge hclk) disable iff (!hresetn)
    addr_phase && !hwrite && wr_hit);

endmodule : pgsm_gpio

// ### testbench/pgsm_board.sv
`timescale 1ns/1ns
module pgsm_board (
  // pins from the device
  input wire pgsm_pkg::pgsm_pads_s pads,
  // board levels on pins nobody drives
  input wire logic [7:0] ext_level,
  // levels seen by the input buffers
  output logic [7:0] pin_level
);
  import pgsm_pkg::*;

  // an enabled pin shows its output buffer, others the board level
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      pin_level[i] = pads.oe[i] ? pads.out[i] : ext_level[i];
  end
endmodule : pgsm_board

// ### testbench/pad_gpio_and_signal_monitor_tb.sv
`timescale 1ns/1ns
module pad_gpio_and_signal_monitor_tb;
  import pgsm_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [7:0] pin_level;
  pgsm_pads_s pads;
  logic scan_active = 1'b0;
  logic clock_output_func = 1'b0;
  logic fast_pad_switching;
  pgsm_debug_s debug = 6'h00;
  logic mon_out;
  logic mon_oe;
  logic [7:0] ext_level = 8'h5a;
  logic [31:0] rd;
  logic [7:0] en_t [4] = '{8'hff, 8'h3c, 8'h00, 8'hcf};
  logic [7:0] val_t [4] = '{8'ha5, 8'h5a, 8'hff, 8'h0f};
  logic [3:0] sc_t = 4'b1010;
  logic [7:0] eo;
  logic [7:0] ev;
  logic [5:0] oh;
  logic eoe;
  logic eout;
  int n_errors = 0;
  int cmp_count = 0;

  always #20 hclk = ~hclk;

  pgsm_gpio #(.SILICON_VERSION(4'h2), .SILICON_SUBVERSION(4'h6)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pin_level(pin_level), .pads(pads),
    .scan_active(scan_active), .clock_output_func(clock_output_func),
    .fast_pad_switching(fast_pad_switching), .debug(debug),
    .monitor_output_pin_out(mon_out), .monitor_output_pin_oe(mon_oe));

  pgsm_board board (.pads(pads), .ext_level(ext_level), .pin_level(pin_level));

  // ****************************************
  // tasks
  // ****************************************
  task automatic results;
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // only the watchdog ends a wait that never sees ready
  task automatic wait_rdy;
    do
      @(posedge hclk);
    while (hreadyout !== 1'b1);
  endtask : wait_rdy

  // one single word transfer, read data left in rd
  task automatic ahb(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy;
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h0, wd};
    wait_rdy;
    rd = hrdata;
  endtask : ahb

  // write, then read of the same word with no idle cycle between them
  task automatic ahb_wr_rd(input logic [7:0] idx, input logic [7:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    wait_rdy;
    hwrite <= 1'b0;
    hwdata <= {24'h0, wd};
    wait_rdy;
    htrans <= 2'h0;
    hsel <= 1'b0;
    wait_rdy;
    rd = hrdata;
  endtask : ahb_wr_rd

  task automatic settle;
    repeat (2) @(posedge hclk);
  endtask : settle

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    settle;
    chk("pads.oe reset", 32'h40, pads.oe);
    ahb(PGSM_IDX_PAD_OUTPUT_ENABLE, 1'b0, 8'h00);
    chk("enable reset", 32'h0, rd);
    ahb(PGSM_IDX_MONITOR_OUTPUT_SELECT, 1'b0, 8'h00);
    chk("select reset", 32'h0, rd);
    ahb(PGSM_IDX_SILICON_REVISION, 1'b1, 8'h00);
    ahb(PGSM_IDX_SILICON_REVISION, 1'b0, 8'h00);
    chk("revision", 32'h26, rd);
    chk("hresp", 32'h0, hresp);
    ahb(8'h50, 1'b0, 8'h00);
    chk("unmapped", 32'h0, rd);
    chk("hreadyout", 32'h1, hreadyout);
    ahb_wr_rd(PGSM_IDX_PAD_OUTPUT_VALUE, 8'h3c);
    chk("value back to back", 32'h3c, rd);
    ahb_wr_rd(PGSM_IDX_MONITOR_OUTPUT_SELECT, 8'hf3);
    chk("select back to back", 32'h83, rd);
    for (int i = 0; i < 4; i++)
    begin
      scan_active <= sc_t[i];
      clock_output_func <= i[0];
      ahb(PGSM_IDX_PAD_OUTPUT_ENABLE, 1'b1, en_t[i]);
      ahb(PGSM_IDX_PAD_OUTPUT_VALUE, 1'b1, val_t[i]);
      settle;
      eo = (sc_t[i] ? (en_t[i] & ~PGSM_SCAN_PIN_MASK) : en_t[i]) | (en_t[i][6] ? 8'h00 : 8'h40);
      ev = val_t[i];
      ev[6] = en_t[i][6] ? val_t[i][6] : i[0];
      ev = ev & eo;
      chk("pads.oe", eo, pads.oe);
      chk("pads.out", ev, pads.out & eo);
      ahb(PGSM_IDX_PAD_INPUT_LEVEL, 1'b0, 8'h00);
      chk("pad_input_level", {24'h0, ev | (ext_level & ~eo)}, rd);
      ahb(PGSM_IDX_PAD_OUTPUT_ENABLE, 1'b0, 8'h00);
      chk("pad_output_enable", en_t[i], rd);
      ahb(PGSM_IDX_PAD_OUTPUT_VALUE, 1'b0, 8'h00);
      chk("pad_output_value", val_t[i], rd);
    end
    for (int c = 0; c < 16; c++)
    begin
      ahb(PGSM_IDX_MONITOR_OUTPUT_SELECT, 1'b1, {c[0], 3'h7, c[3:0]});
      ahb(PGSM_IDX_MONITOR_OUTPUT_SELECT, 1'b0, 8'h00);
      chk("monitor_output_select", {c[0], 3'h0, c[3:0]}, rd);
      chk("fast_pad_switching", c[0], fast_pad_switching);
      oh = (c >= 4 && c <= 9) ? 6'h01 << (9 - c) : 6'h00;
      eoe = (c >= 2 && c <= 9);
      for (int p = 0; p < 2; p++)
      begin
        debug <= p[0] ? ~oh : oh;
        settle;
        eout = (c == 3) || (c >= 4 && p == 0);
        chk("monitor oe", eoe, mon_oe);
        if (eoe)
          chk("monitor out", eout, mon_out);
      end
    end
    // second reset in mid-run
    @(posedge hclk);
    hresetn <= 1'b0;
    settle;
    hresetn <= 1'b1;
    ahb(PGSM_IDX_PAD_OUTPUT_VALUE, 1'b0, 8'h00);
    chk("value after reset", 32'h0, rd);
    chk("fast after reset", 32'h0, fast_pad_switching);
    results;
  end

  // ****************************************
  // watchdog
  // ****************************************
  initial
  begin
    repeat (5000) @(posedge hclk);
    n_errors++;
    results;
  end
endmodule : pad_gpio_and_signal_monitor_tb
